/* File: pfm_fault_monitor.sv */
// Summary of operation
// - bulk ov over 10 us sets its status bit and irq together
// - first bulk ov leaves power-good alone, regulation continues
// - own clear bit or global clear drops bulk ov status and irq
// - bulk ov still present keeps status bit and irq set
// - programmable: bulk ov over 20 us disables bucks, pg low, ldos on
// - enable after clear restarts bucks; pg released once all normal
// - secure: bulk ov over 20 us disables bucks, pg low, config mode
// - buck below low or above high pg threshold is pg fault
// - each ldo below its selected threshold is pg fault
// - pg fault over 10 us sets status, pulls pg and irq low
// - clearing pg status releases lines unless fault persists
// - mask bits stop irq or pg assertion for an event
// - buck ov checked against its two-bit threshold field
// - programmable: buck ov over 20 us disables bucks, sets status
// - secure: buck ov over 20 us likewise disables bucks, sets status
// - after shutdown, clear status first, then enable restarts
// - buck uv checked against its two-bit low threshold field
// - bulk input under lockout level handled as undervoltage
// - programmable: uv over 20 us disables bucks, sets uv status
// - secure: uv over 20 us disables bucks, sets uv and summary bit
// - masks gate the lines and the enable check, never status or shutdown
// - pg stays low after fault clears until status is cleared
module pfm_fault_monitor
    import pfm_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        bulk_input_supply_ov,
    input  wire logic        bulk_input_supply_uvlo,
    input  wire logic [2:0]  buck_pg_under,
    input  wire logic [2:0]  buck_pg_over,
    input  wire logic [2:0]  buck_ov,
    input  wire logic [2:0]  buck_uv,
    input  wire logic        ldo_rail_high_low,
    input  wire logic        ldo_rail_low_low,
    output logic [2:0]       buck_pg_low_sel,
    output logic [5:0]       buck_pg_high_sel,
    output logic [5:0]       buck_ov_sel,
    output logic [5:0]       buck_uv_sel,
    output logic [1:0]       ldo_low_sel,
    output logic             bulk_ov_sel,
    output logic             switching_on,
    output logic             ldo_on,
    output logic             config_mode,
    output logic             regulator_off_command,
    input  wire logic        general_status_irq_n_in,
    output logic             general_status_irq_n_out,
    output logic             general_status_irq_n_oe_n,
    input  wire logic        power_ok_line_in,
    output logic             power_ok_line_out,
    output logic             power_ok_line_oe_n
);
    import pfm_pkg::*;

    function automatic logic is_stat(input logic [5:0] idx);
        is_stat = (idx == IDX_STAT0) || (idx == IDX_STAT1) ||
                  (idx == IDX_STAT_OV) || (idx == IDX_STAT_UV) ||
                  (idx == IDX_STAT2);
    endfunction

    logic [7:0]     cfg [0:63];
    logic [NEV-1:0] st;
    logic [NEV-1:0] done;
    logic [NEV-1:0] cond;
    logic [NEV-1:0] clr;
    logic [NEV-1:0] set;
    logic [15:0]    sync1;
    logic [15:0]    sync2;
    pfm_state_e     state;
    pfm_state_e     next_state;
    logic           drive_lvl;

    // ---------------- register bus ----------------
    logic       wr_go;
    logic       rd_go;
    logic       wr_hit;
    logic       rd_hit;
    logic       wr_en;
    logic [5:0] wi;
    logic [5:0] ri;
    logic [7:0] wbyte;
    logic [7:0] rd_stat;
    logic [7:0] rd_byte;
    logic       gclr;
    logic       cmd_on;

    // one write and one read in flight; aw and w taken together
    assign wr_go  = awvalid && wvalid && !awready && !bvalid;
    assign rd_go  = arvalid && !arready && !rvalid;
    assign wi     = awaddr[7:2];
    assign ri     = araddr[7:2];
    assign wr_hit = (awaddr[11:8] == 4'h0);
    assign rd_hit = (araddr[11:8] == 4'h0);
    assign wr_en  = wr_go && wr_hit && wstrb[0];
    assign wbyte  = wdata[7:0];
    assign gclr   = wr_en && (wi == IDX_GCLR) && wbyte[BIT_GCLR];
    assign cmd_on = wr_en && (wi == IDX_CMD) && wbyte[BIT_CMD_ON];

    always_comb begin
        rd_stat = 8'h00;
        for (int k = 0; k < NEV; k++) begin
            if (ri == ST_IDX[k] && st[k]) begin
                rd_stat[ST_BIT[k]] = 1'b1;
            end
        end
    end

    assign rd_byte = is_stat(ri) ? rd_stat : cfg[ri];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            awready <= wr_go;
            wready  <= wr_go;
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= rd_go;
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
                rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // plain byte store; status and clear indices hold nothing here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 64; i++) begin
                cfg[i] <= CFG_RST;
            end
        end else if (wr_en && !is_stat(wi) && wi != IDX_CLR0 &&
                     wi != IDX_GCLR) begin
            // enable bit is a command, never stored
            cfg[wi] <= (wi == IDX_CMD) ? {1'b0, wbyte[6:0]} : wbyte;
        end
    end

    // threshold selects for the analog comparators
    assign buck_pg_low_sel  = {cfg[IDX_C_PGLO][BIT_PGLO],
                               cfg[IDX_B_PGLO][BIT_PGLO],
                               cfg[IDX_A_PGLO][BIT_PGLO]};
    assign buck_pg_high_sel = {cfg[IDX_C_THR][LSB_PGHI +: 2],
                               cfg[IDX_B_THR][LSB_PGHI +: 2],
                               cfg[IDX_A_THR][LSB_PGHI +: 2]};
    assign buck_ov_sel      = {cfg[IDX_C_THR][LSB_OV +: 2],
                               cfg[IDX_B_THR][LSB_OV +: 2],
                               cfg[IDX_A_THR][LSB_OV +: 2]};
    assign buck_uv_sel      = {cfg[IDX_C_THR][LSB_UV +: 2],
                               cfg[IDX_B_THR][LSB_UV +: 2],
                               cfg[IDX_A_THR][LSB_UV +: 2]};
    assign ldo_low_sel      = {cfg[IDX_LDO_CFG][BIT_LDO_H],
                               cfg[IDX_LDO_CFG][BIT_LDO_L]};
    assign bulk_ov_sel      = cfg[IDX_BULK_CFG][BIT_BULKOV];

    // ---------------- comparator inputs ----------------
    logic [15:0] raw;
    logic        bov;
    logic        buv;
    logic [2:0]  pgu;
    logic [2:0]  pgo;
    logic [2:0]  sov;
    logic [2:0]  suv;
    logic [1:0]  ldo;
    logic        rails_on;
    logic        in_reg;
    logic        prog;
    logic        all_ok;

    assign raw = {ldo_rail_low_low, ldo_rail_high_low, buck_uv, buck_ov,
                  buck_pg_over, buck_pg_under, bulk_input_supply_uvlo,
                  bulk_input_supply_ov};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 16'h0000;
            sync2 <= 16'h0000;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    assign bov      = sync2[0];
    assign buv      = sync2[1];
    assign pgu      = sync2[4:2];
    assign pgo      = sync2[7:5];
    assign sov      = sync2[10:8];
    assign suv      = sync2[13:11];
    assign ldo      = sync2[15:14];
    assign rails_on = (state == PFM_RAMP) || (state == PFM_REG);
    assign in_reg   = (state == PFM_REG);
    assign prog     = cfg[IDX_MODE][BIT_MODE];
    assign all_ok   = !(|{pgu, pgo, sov, suv, ldo, bov, buv});

    // ---------------- persistence timers ----------------
    // buck checks only mean something while the bucks switch
    assign cond[0]     = bov;
    assign cond[3:1]   = in_reg ? (pgu | pgo) : 3'h0;
    assign cond[5:4]   = {ldo[1], ldo[0]};
    assign cond[8:6]   = rails_on ? sov : 3'h0;
    assign cond[11:9]  = rails_on ? suv : 3'h0;
    assign cond[12]    = buv;
    assign cond[13]    = bov && rails_on;

    genvar k;
    generate
        for (k = 0; k < NEV; k++) begin : g_tmr
            localparam logic [9:0] LIM = (k < 6) ? FLAG_CYC : SHUT_CYC;
            logic [9:0] cnt;
            assign done[k] = (cnt == LIM);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt <= 10'h000;
                end else if (!cond[k]) begin
                    cnt <= 10'h000;
                end else if (!done[k]) begin
                    cnt <= cnt + 10'h001;
                end
            end
        end
    endgenerate

    // ---------------- sticky status ----------------
    logic sd;
    logic sd_cfg;

    assign sd     = rails_on && (done[13] || (|done[12:6]));
    assign sd_cfg = !prog && done[13];
    assign set[12:0] = done[12:0];
    assign set[13]   = !prog && (|done[12:9]);

    generate
        for (k = 0; k < NEV; k++) begin : g_clr
            if (k == 0) begin : g_own
                assign clr[k] = gclr ||
                    (wr_en && wi == IDX_CLR0 && wbyte[0]) ||
                    (wr_en && wi == ST_IDX[k] && wbyte[ST_BIT[k]]);
            end else begin : g_w1c
                assign clr[k] = gclr ||
                    (wr_en && wi == ST_IDX[k] && wbyte[ST_BIT[k]]);
            end
        end
    endgenerate

    // a persisting fault re-sets its bit in the clearing cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= (st & ~clr) | set;
        end
    end

    // ---------------- line drive ----------------
    logic [NEV-1:0] imask;
    logic [NEV-1:0] pmask;
    logic           irq_now;
    logic           pg_hold;
    logic           pg_low;

    assign imask   = {cfg[IDX_IMASK_HI][5:0], cfg[IDX_IMASK_LO]};
    assign pmask   = {cfg[IDX_PMASK_HI][5:0], cfg[IDX_PMASK_LO]};
    assign irq_now = |(st & ~imask);
    // bulk ov status alone never touches power-good
    assign pg_hold = |(st[13:1] & ~pmask[13:1]);
    assign pg_low  = !in_reg || pg_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_lvl                 <= 1'b0;
            general_status_irq_n_oe_n <= 1'b1;
            power_ok_line_oe_n        <= 1'b0;
        end else begin
            drive_lvl                 <= 1'b0;
            general_status_irq_n_oe_n <= !irq_now;
            power_ok_line_oe_n        <= !pg_low;
        end
    end

    assign general_status_irq_n_out = drive_lvl;
    assign power_ok_line_out        = drive_lvl;

    // ---------------- regulator control ----------------
    // enable refused while irq pending, so a stale fault cannot restart
    always_comb begin
        next_state = state;
        case (state)
            PFM_CFG, PFM_OFF: begin
                if (cmd_on && !irq_now) begin
                    next_state = PFM_RAMP;
                end
            end
            PFM_RAMP: begin
                if (sd) begin
                    next_state = sd_cfg ? PFM_CFG : PFM_OFF;
                end else if (all_ok) begin
                    next_state = PFM_REG;
                end
            end
            PFM_REG: begin
                if (sd) begin
                    // secure bulk ov falls back to configuration
                    next_state = sd_cfg ? PFM_CFG : PFM_OFF;
                end
            end
            default: next_state = PFM_CFG;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                 <= PFM_CFG;
            switching_on          <= 1'b0;
            config_mode           <= 1'b1;
            regulator_off_command <= 1'b0;
            ldo_on                <= 1'b0;
        end else begin
            state                 <= next_state;
            switching_on          <= (next_state == PFM_RAMP) ||
                                     (next_state == PFM_REG);
            config_mode           <= (next_state == PFM_CFG);
            regulator_off_command <= sd;
            ldo_on                <= 1'b1;
        end
    end

endmodule

/* File: pfm_pkg.sv */
package pfm_pkg;

    // clock and persistence limits
    localparam int CLK_PERIOD_NS = 20;
    localparam int FLAG_DELAY_NS = 10000;
    localparam int SHUT_DELAY_NS = 20000;
    localparam logic [9:0] FLAG_CYC = 10'(FLAG_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [9:0] SHUT_CYC = 10'(SHUT_DELAY_NS / CLK_PERIOD_NS);

    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_STAT0    = 6'h08;
    localparam logic [5:0] IDX_STAT1    = 6'h09;
    localparam logic [5:0] IDX_STAT_OV  = 6'h0A;
    localparam logic [5:0] IDX_STAT_UV  = 6'h0B;
    localparam logic [5:0] IDX_CLR0     = 6'h10;
    localparam logic [5:0] IDX_GCLR     = 6'h14;
    localparam logic [5:0] IDX_IMASK_LO = 6'h16;
    localparam logic [5:0] IDX_IMASK_HI = 6'h17;
    localparam logic [5:0] IDX_PMASK_LO = 6'h18;
    localparam logic [5:0] IDX_PMASK_HI = 6'h19;
    localparam logic [5:0] IDX_LDO_CFG  = 6'h1A;
    localparam logic [5:0] IDX_BULK_CFG = 6'h1B;
    localparam logic [5:0] IDX_A_PGLO   = 6'h21;
    localparam logic [5:0] IDX_A_THR    = 6'h22;
    localparam logic [5:0] IDX_B_PGLO   = 6'h25;
    localparam logic [5:0] IDX_B_THR    = 6'h26;
    localparam logic [5:0] IDX_C_PGLO   = 6'h27;
    localparam logic [5:0] IDX_C_THR    = 6'h28;
    localparam logic [5:0] IDX_MODE     = 6'h2F;
    localparam logic [5:0] IDX_CMD      = 6'h32;
    localparam logic [5:0] IDX_STAT2    = 6'h33;

    // field positions
    localparam int BIT_GCLR   = 0;
    localparam int BIT_CMD_ON = 7;
    localparam int BIT_MODE   = 2;
    localparam int BIT_BULKOV = 7;
    localparam int BIT_LDO_H  = 2;
    localparam int BIT_LDO_L  = 0;
    localparam int BIT_PGLO   = 0;
    localparam int LSB_PGHI   = 6;
    localparam int LSB_OV     = 4;
    localparam int LSB_UV     = 2;

    // events: 0 bulk ov, 1-3 buck pg, 4-5 ldo pg, 6-8 buck ov,
    // 9-11 buck uv, 12 bulk uvlo, 13 secure uv summary
    localparam int NEV = 14;
    localparam logic [NEV-1:0][5:0] ST_IDX = '{
        6'h0B, 6'h33, 6'h0B, 6'h0B, 6'h0B, 6'h0A, 6'h0A,
        6'h0A, 6'h33, 6'h09, 6'h08, 6'h08, 6'h08, 6'h08};
    localparam logic [NEV-1:0][2:0] ST_BIT = '{
        3'h2, 3'h3, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5,
        3'h7, 3'h2, 3'h5, 3'h2, 3'h3, 3'h5, 3'h0};

    localparam logic [7:0] CFG_RST     = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PFM_CFG,
        PFM_RAMP,
        PFM_REG,
        PFM_OFF
    } pfm_state_e;

endpackage

/* File: pfm_board_lines.sv */
module pfm_board_lines (
    input  wire logic irq_oe_n,
    input  wire logic irq_out,
    input  wire logic pg_oe_n,
    input  wire logic pg_out,
    output logic      irq_level,
    output logic      pg_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // board pull-ups: a released open-drain line reads high
    assign irq_level = irq_oe_n ? 1'b1 : irq_out;
    assign pg_level  = pg_oe_n ? 1'b1 : pg_out;
endmodule

/* File: pfm_fault_monitor_properties.sv */
module pfm_fault_monitor_properties
    import pfm_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [11:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wvalid,
    input wire logic        bvalid,
    input wire logic        switching_on,
    input wire logic        ldo_on,
    input wire logic        regulator_off_command,
    input wire logic        general_status_irq_n_oe_n,
    input wire logic        power_ok_line_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_take;
        awvalid && wvalid && !awready && !bvalid;
    endsequence
    sequence s_enable;
        s_take ##0 (awaddr[11:2] == {4'h0, IDX_CMD} && wdata[7] && wstrb[0]);
    endsequence
    property p_ldo_kept;
        $past(aresetn) |-> ldo_on;
    endproperty
    a_ldo_kept: assert property (p_ldo_kept)
        else $error("ldo rails dropped");
    property p_off_stops;
        regulator_off_command |-> !switching_on ##1 !power_ok_line_oe_n;
    endproperty
    a_off_stops: assert property (p_off_stops)
        else $error("shutdown left rails or pg wrong");
    property p_off_pulse;
        regulator_off_command |=> !regulator_off_command;
    endproperty
    a_off_pulse: assert property (p_off_pulse)
        else $error("off command longer than one cycle");
    property p_pg_low_off;
        !switching_on && !$past(switching_on) |-> !power_ok_line_oe_n;
    endproperty
    a_pg_low_off: assert property (p_pg_low_off)
        else $error("pg released with rails off");
    property p_pg_rel;
        $rose(power_ok_line_oe_n) |-> switching_on;
    endproperty
    a_pg_rel: assert property (p_pg_rel)
        else $error("pg released without rails");
    property p_irq_rel;
        $rose(general_status_irq_n_oe_n) |-> $past(bvalid) || $past(bvalid, 2);
    endproperty
    a_irq_rel: assert property (p_irq_rel)
        else $error("irq released without a write");
    property p_en_refused;
        s_enable ##0 (!general_status_irq_n_oe_n && !switching_on)
            |=> (!switching_on) [*3];
    endproperty
    a_en_refused: assert property (p_en_refused)
        else $error("enable taken with irq asserted");
    property p_en_ok;
        s_enable ##0 (general_status_irq_n_oe_n && !switching_on)
            |=> ##[0:3] switching_on;
    endproperty
    a_en_ok: assert property (p_en_ok)
        else $error("enable did not start rails");
endmodule

/* File: tb_pfm_fault_monitor.sv */
module tb_pfm_fault_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    import pfm_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [7:0]  v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, ldo_sel;
    logic        awready, wready, bvalid, arready, rvalid, bov_sel;
    logic        ov_in, uvlo_in, ldoh, ldol, sw_on, ldo_on, cfg_m, off_cmd;
    logic [2:0]  pgu, pgo, bov, buv, pgl_sel;
    logic [5:0]  pgh_sel, ov_sel, uv_sel;
    logic        irq_o, irq_oe_n, pg_o, pg_oe_n, irq_lvl, pg_lvl;
    logic [5:0]  thr [3] = '{IDX_A_THR, IDX_B_THR, IDX_C_THR};
    logic [5:0]  pglo [3] = '{IDX_A_PGLO, IDX_B_PGLO, IDX_C_PGLO};
    int          failures = 0, n_checks = 0, cyc = 0;
    always #10 aclk = ~aclk;
    pfm_fault_monitor pfm_fault_monitor_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .bulk_input_supply_ov(ov_in), .bulk_input_supply_uvlo(uvlo_in),
        .buck_pg_under(pgu), .buck_pg_over(pgo), .buck_ov(bov),
        .buck_uv(buv), .ldo_rail_high_low(ldoh), .ldo_rail_low_low(ldol),
        .buck_pg_low_sel(pgl_sel), .buck_pg_high_sel(pgh_sel),
        .buck_ov_sel(ov_sel), .buck_uv_sel(uv_sel), .ldo_low_sel(ldo_sel),
        .bulk_ov_sel(bov_sel), .switching_on(sw_on), .ldo_on(ldo_on),
        .config_mode(cfg_m), .regulator_off_command(off_cmd),
        .general_status_irq_n_in(irq_lvl), .general_status_irq_n_out(irq_o),
        .general_status_irq_n_oe_n(irq_oe_n), .power_ok_line_in(pg_lvl),
        .power_ok_line_out(pg_o), .power_ok_line_oe_n(pg_oe_n)
    );
    pfm_board_lines pfm_board_lines_i (
        .irq_oe_n(irq_oe_n), .irq_out(irq_o), .pg_oe_n(pg_oe_n),
        .pg_out(pg_o), .irq_level(irq_lvl), .pg_level(pg_lvl)
    );
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] adr(input logic [5:0] idx);
        return {4'h0, idx, 2'h0};
    endfunction
    // status place: index in [8:3], bit in [2:0]
    function automatic logic [8:0] loc(input int k, input int r);
        case (k)
            0: return {IDX_STAT0, 3'h0};
            1: return {IDX_STAT_OV, (r == 0) ? 3'h7 : (r == 1) ? 3'h5 : 3'h4};
            2: return {IDX_STAT_UV, (r == 0) ? 3'h3 : (r == 1) ? 3'h1 : 3'h0};
            3: return {IDX_STAT2, 3'h3};
            6: return {IDX_STAT1, 3'h5};
            7: return {IDX_STAT2, 3'h2};
            default: return {IDX_STAT0,
                             (r == 0) ? 3'h5 : (r == 1) ? 3'h3 : 3'h2};
        endcase
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] dat,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, dat};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // only the bench timeout ends this wait
        do @(posedge aclk); while (bvalid !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        chk({awready, wready}, 2'h3);
        chk(bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b0;
        q = rdata;
        chk(arready, 1'b1);
        chk(rresp, er);
    endtask
    task automatic sbit(input logic [8:0] l, input logic e);
        logic [31:0] q;
        rd(adr(l[8:3]), q);
        chk(q[l[2:0]], e);
    endtask
    task automatic setf(input int k, input int r, input logic s);
        case (k)
            0: ov_in <= s;
            1: bov[r] <= s;
            2: buv[r] <= s;
            3: uvlo_in <= s;
            4: pgu[r] <= s;
            5: pgo[r] <= s;
            6: ldoh <= s;
            default: ldol <= s;
        endcase
    endtask
    task automatic en_rails();
        int n;
        wr(adr(IDX_CMD), 8'h80);
        n = 0;
        do @(posedge aclk); while (pg_lvl !== 1'b1 && ++n < 100);
        chk({sw_on, pg_lvl}, 2'h3);
    endtask
    task automatic pgf(input int k);
        int r;
        logic [8:0] l;
        logic [7:0] m;
        r = $urandom_range(2);
        l = loc(k, r);
        m = 8'h01 << ((k < 6) ? r + 1 : k - 2);
        setf(k, r, 1'b1);
        repeat (600) @(posedge aclk);
        chk({pg_lvl, irq_lvl, sw_on}, 3'h1);
        sbit(l, 1'b1);
        wr(adr(IDX_GCLR), 8'h01);
        sbit(l, 1'b1);
        wr(adr(IDX_IMASK_LO), m);
        wr(adr(IDX_PMASK_LO), m);
        repeat (3) @(posedge aclk);
        chk({pg_lvl, irq_lvl}, 2'h3);
        sbit(l, 1'b1);
        wr(adr(IDX_PMASK_LO), 8'h00);
        setf(k, r, 1'b0);
        repeat (10) @(posedge aclk);
        chk(pg_lvl, 1'b0);
        wr(adr(IDX_GCLR), 8'h01);
        wr(adr(IDX_IMASK_LO), 8'h00);
        repeat (3) @(posedge aclk);
        chk({pg_lvl, irq_lvl, sw_on}, 3'h7);
        $display("pg test %0d rail %0d done", k, r);
    endtask
    task automatic shut(input int k, input logic prog);
        int r;
        logic [8:0] l;
        r = $urandom_range(2);
        l = loc(k, r);
        wr(adr(IDX_MODE), {5'h0, prog, 2'h0});
        en_rails();
        setf(k, r, 1'b1);
        repeat (1100) @(posedge aclk);
        chk({sw_on, ldo_on, irq_lvl}, 3'h2);
        chk(cfg_m, k == 0 && !prog);
        setf(k, r, 1'b0);
        repeat (20) @(posedge aclk);
        chk(pg_lvl, 1'b0);
        sbit(l, 1'b1);
        if (k >= 2 && !prog)
            sbit({IDX_STAT_UV, 3'h2}, 1'b1);
        wr(adr(IDX_CMD), 8'h80);
        repeat (5) @(posedge aclk);
        chk(sw_on, 1'b0);
        wr(adr(IDX_GCLR), 8'h01);
        repeat (3) @(posedge aclk);
        chk(irq_lvl, 1'b1);
        sbit(l, 1'b0);
        $display("shutdown test %0d mode %0d done", k, prog);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {ov_in, uvlo_in, ldoh, ldol, pgu, pgo, bov, buv} = '0;
        void'($urandom(79));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({pg_lvl, irq_lvl}, 2'h1);
        sbit({IDX_STAT0, 3'h0}, 1'b0);
        sbit({IDX_MODE, 3'h2}, 1'b0);
        wr(12'h100, 8'h5A, RESP_SLVERR);
        rd(12'h1FC, d, RESP_SLVERR);
        chk(d, 32'h0);
        for (int r = 0; r < 3; r++) begin
            v = 8'($urandom);
            wr(adr(thr[r]), v);
            chk({pgh_sel[2*r+:2], ov_sel[2*r+:2], uv_sel[2*r+:2]},
                v[7:2]);
            wr(adr(pglo[r]), v);
            chk(pgl_sel[r], v[0]);
            rd(adr(thr[r]), d);
            chk(d, {24'h0, v});
        end
        wr(adr(IDX_LDO_CFG), v);
        chk(ldo_sel, {v[2], v[0]});
        wr(adr(IDX_BULK_CFG), v);
        chk(bov_sel, v[7]);
        $display("config test done");
        en_rails();
        // a 300-cycle burst under the flag limit, then a 560-cycle burst that passes it
        setf(0, 0, 1'b1);
        repeat (300) @(posedge aclk);
        setf(0, 0, 1'b0);
        repeat (300) @(posedge aclk);
        chk(irq_lvl, 1'b1);
        setf(0, 0, 1'b1);
        repeat (560) @(posedge aclk);
        chk({irq_lvl, pg_lvl, sw_on}, 3'h3);
        sbit({IDX_STAT0, 3'h0}, 1'b1);
        wr(adr(IDX_CLR0), 8'h01);
        sbit({IDX_STAT0, 3'h0}, 1'b1);
        chk(irq_lvl, 1'b0);
        setf(0, 0, 1'b0);
        repeat (5) @(posedge aclk);
        wr(adr(IDX_CLR0), 8'h01);
        repeat (3) @(posedge aclk);
        chk(irq_lvl, 1'b1);
        sbit({IDX_STAT0, 3'h0}, 1'b0);
        $display("bulk flag test done");
        for (int k = 4; k < 8; k++)
            pgf(k);
        for (int k = 0; k < 4; k++) begin
            shut(k, 1'b1);
            shut(k, 1'b0);
        end
        close_out();
    end
endmodule
bind pfm_fault_monitor pfm_fault_monitor_properties
    pfm_fault_monitor_properties_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .bvalid(bvalid),
    .switching_on(switching_on), .ldo_on(ldo_on),
    .regulator_off_command(regulator_off_command),
    .general_status_irq_n_oe_n(general_status_irq_n_oe_n),
    .power_ok_line_oe_n(power_ok_line_oe_n)
);
